// File: srg_acc_if.sv
// Access events between the register file and the guard sequencer
`timescale 1ns/1ns
interface srg_acc_if;
  logic ev_valid;
  srg_pkg::srg_kind_t ev_kind;
  logic ev_flag;
  logic accept;
  logic perr;
  logic armed;

  modport guard (
    input ev_valid,
    input ev_kind,
    input ev_flag,
    output accept,
    output perr,
    output armed
  );

  modport user (
    output ev_valid,
    output ev_kind,
    output ev_flag,
    input accept,
    input perr,
    input armed
  );
endinterface

// File: srg_assertions.sv
// Port checks for the special register write guard
`timescale 1ns/1ns
module srg_assertions #(
  parameter int PROT_COUNT = 8
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Register bus
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  // Guard outputs
  input wire logic [8*PROT_COUNT-1:0] protected_value_o,
  input wire logic irq_holdoff_o
);
  logic [7:0] aw_q;
  logic [7:0] ar_q;
  logic [7:0] wd_q;
  logic [3:0] ws_q;
  logic cmd_wr;
  logic prot_wr;
  int idx;
  // Last taken write and read
  always_ff @(posedge ref_clk_i) begin
    if (s_axi_awvalid_i && s_axi_awready_o) aw_q <= s_axi_awaddr_i;
    if (s_axi_wvalid_i && s_axi_wready_o) wd_q <= s_axi_wdata_i[7:0];
    if (s_axi_wvalid_i && s_axi_wready_o) ws_q <= s_axi_wstrb_i;
    if (s_axi_arvalid_i && s_axi_arready_o) ar_q <= s_axi_araddr_i;
  end
  assign cmd_wr = aw_q[7:2] == srg_pkg::CMD_OFFSET[7:2];
  assign prot_wr = ws_q[0] && aw_q >= srg_pkg::PROT_BASE
    && int'(aw_q) < int'(srg_pkg::PROT_BASE) + 4 * PROT_COUNT;
  assign idx = (int'(aw_q) - int'(srg_pkg::PROT_BASE)) / 4;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  AST_CMD_ARMS: assert property ($rose(s_axi_bvalid_o) && cmd_wr &&
    ws_q == srg_pkg::STRB_BYTE0 && !$past(irq_holdoff_o) |-> irq_holdoff_o)
    else $error("unlock not armed by command write");
  AST_DISARM: assert property ($rose(s_axi_bvalid_o) && ws_q[0] &&
    s_axi_bresp_o == srg_pkg::RESP_OKAY && $past(irq_holdoff_o) |-> !irq_holdoff_o)
    else $error("unlock still armed after a write");
  AST_PROT_DROP: assert property ($rose(s_axi_bvalid_o) && prot_wr &&
    !$past(irq_holdoff_o) |-> $stable(protected_value_o))
    else $error("unarmed protected write changed contents");
  AST_PROT_TAKE: assert property ($rose(s_axi_bvalid_o) && prot_wr &&
    $past(irq_holdoff_o) |-> protected_value_o[8*idx +: 8] == wd_q)
    else $error("armed protected write not stored");
  AST_HOLD_QUIET: assert property (!$rose(s_axi_bvalid_o) && !$past(reset_i)
    |-> $stable(irq_holdoff_o))
    else $error("unlock changed without a write");
  AST_PROT_QUIET: assert property (!$rose(s_axi_bvalid_o) && !$past(reset_i)
    |-> $stable(protected_value_o))
    else $error("protected contents changed without a write");
  AST_CMD_READ: assert property ($rose(s_axi_rvalid_o) &&
    ar_q[7:2] == srg_pkg::CMD_OFFSET[7:2] |-> s_axi_rdata_o[7:0] == srg_pkg::CMD_READ_VALUE)
    else $error("command read value wrong");
  AST_STATUS_READ: assert property ($rose(s_axi_rvalid_o) &&
    ar_q[7:2] == srg_pkg::STATUS_OFFSET[7:2] |-> s_axi_rdata_o[31:1] == 31'h0)
    else $error("status upper bits not zero");
  AST_CMD_STRB: assert property ($rose(s_axi_bvalid_o) && cmd_wr &&
    ws_q != srg_pkg::STRB_BYTE0 |-> s_axi_bresp_o == srg_pkg::RESP_SLVERR
    ##0 $stable(irq_holdoff_o))
    else $error("wide command write not refused");
endmodule
bind srg_special_register_write_guard srg_assertions #(.PROT_COUNT(PROT_COUNT))
  srg_assertions_inst (
  .ref_clk_i, .reset_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
  .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
  .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
  .protected_value_o, .irq_holdoff_o
);

// File: srg_cpu_model.sv
// Bus master standing in for the processor core
`timescale 1ns/1ns
module srg_cpu_model (
  // Clock
  input wire logic ref_clk_i,
  // Write channels
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  // Read channels
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o,
  // Answer never came
  output logic hang_o
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o, hang_o} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    r = 2'hX;
    @(posedge ref_clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= s;
    awvalid_o <= 1'h1;
    wvalid_o <= 1'h1;
    bready_o <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge ref_clk_i);
      if (awvalid_o && awready_i) awvalid_o <= 1'h0;
      if (wvalid_o && wready_i) wvalid_o <= 1'h0;
      if (bvalid_i) begin
        r = bresp_i;
        bready_o <= 1'h0;
        return;
      end
    end
    hang_o <= 1'h1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    d = 32'hX;
    r = 2'hX;
    @(posedge ref_clk_i);
    araddr_o <= a;
    arvalid_o <= 1'h1;
    rready_o <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge ref_clk_i);
      if (arvalid_o && arready_i) arvalid_o <= 1'h0;
      if (rvalid_i) begin
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'h0;
        return;
      end
    end
    hang_o <= 1'h1;
  endtask
endmodule

// File: srg_guard.sv
// Unlock sequencer and protection error flag
`timescale 1ns/1ns
module srg_guard (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Access events
  srg_acc_if.guard acc
);

  logic armed_reg;
  logic armed_next;
  logic perr_reg;
  logic perr_next;
  logic accept_c;

  always_comb begin
    armed_next = armed_reg;
    perr_next = perr_reg;
    accept_c = 1'b0;
    if (acc.ev_valid) begin
      armed_next = 1'b0; // (R12)
      if (armed_reg) begin
        unique case (acc.ev_kind)
          srg_pkg::KIND_PROT: accept_c = 1'b1; // (R2)
          srg_pkg::KIND_CMD: perr_next = 1'b1; // (R9)
          srg_pkg::KIND_STATUS: perr_next = acc.ev_flag; // (R8)
          srg_pkg::KIND_OTHER: perr_next = 1'b1; // (R4)
          srg_pkg::KIND_BITREAD: perr_next = 1'b1; // (R5)
        endcase
      end else begin
        unique case (acc.ev_kind)
          srg_pkg::KIND_CMD: armed_next = 1'b1; // (R2)
          srg_pkg::KIND_PROT: perr_next = 1'b1; // (R3)
          srg_pkg::KIND_STATUS: perr_next = acc.ev_flag; // (R6)
          srg_pkg::KIND_OTHER: perr_next = perr_reg;
          srg_pkg::KIND_BITREAD: perr_next = perr_reg;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      armed_reg <= 1'b0;
      perr_reg <= srg_pkg::STATUS_RESET[srg_pkg::PERR_BIT]; // (R7)
    end else begin
      armed_reg <= armed_next;
      perr_reg <= perr_next;
    end
  end

  assign acc.accept = accept_c;
  assign acc.perr = perr_reg;
  assign acc.armed = armed_reg;

endmodule

// File: srg_pkg.sv
// Shared constants and types for the special register write guard
package srg_pkg;

  // Register byte offsets
  localparam logic [7:0] CMD_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] BITOP_OFFSET = 8'h08;
  localparam logic [7:0] PROT_BASE = 8'h20;
  localparam logic [7:0] PLAIN_BASE = 8'h40;

  // Reset values and command read value
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] PROT_RESET = 8'h00;
  localparam logic [7:0] PLAIN_RESET = 8'h00;
  localparam logic [7:0] CMD_READ_VALUE = 8'h00;

  // Field positions
  localparam int PERR_BIT = 0;
  localparam int BITOP_ADDR_LSB = 0;
  localparam int BITOP_NUM_LSB = 8;
  localparam int BITOP_OP_LSB = 12;
  localparam int BITOP_TEST_BIT = 0;

  // Byte strobe for a byte-wide access
  localparam logic [3:0] STRB_BYTE0 = 4'h1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Bit manipulation operations
  localparam logic [1:0] OP_TEST = 2'h0;
  localparam logic [1:0] OP_SET = 2'h1;
  localparam logic [1:0] OP_CLEAR = 2'h2;
  localparam logic [1:0] OP_INVERT = 2'h3;

  // Address classes
  typedef enum {
    CLS_NONE,
    CLS_CMD,
    CLS_STATUS,
    CLS_BITOP,
    CLS_PROT,
    CLS_PLAIN
  } srg_class_t;

  // Access kinds seen by the guard
  typedef enum {
    KIND_CMD,
    KIND_PROT,
    KIND_STATUS,
    KIND_OTHER,
    KIND_BITREAD
  } srg_kind_t;

endpackage

// File: srg_special_register_write_guard.sv
// AXI4-Lite register file with write-protected special registers
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns

// Notes on behaviour
// (R1) Command register: byte writes only, reads meaningless
// (R2) Protected write valid only right after command
// (R3) Unarmed protected write sets the error flag
// (R4) Armed write to unprotected register sets error
// (R5) Plain reads keep unlock; bit reads do not
// (R6) Writing zero clears the error flag
// (R7) Reset loads status with zero
// (R8) Clearing write after command wins over error
// (R9) Repeated command write sets the error flag
// (R10) Status reachable by byte or bit access
// (R11) Interrupts held off while unlock is armed
// (R12) Rejected writes dropped; unlock ends after one write; here writes refused with SLVERR or without the byte 0 strobe leave it armed
module srg_special_register_write_guard #(
  parameter int PROT_COUNT = 8,
  parameter int PLAIN_COUNT = 4
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Protected register contents and interrupt hold-off
  output logic [8*PROT_COUNT-1:0] protected_value_o,
  output logic irq_holdoff_o
);

  srg_acc_if acc ();

  // Write channel state
  logic aw_held_reg;
  logic aw_held_next;
  logic [7:0] awaddr_reg;
  logic [7:0] awaddr_next;
  logic w_held_reg;
  logic w_held_next;
  logic [31:0] wdata_reg;
  logic [31:0] wdata_next;
  logic [3:0] wstrb_reg;
  logic [3:0] wstrb_next;
  logic awready_reg;
  logic awready_next;
  logic wready_reg;
  logic wready_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;

  // Read channel state
  logic arready_reg;
  logic arready_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;

  // Register storage
  logic [7:0] prot_reg [PROT_COUNT];
  logic [7:0] prot_next [PROT_COUNT];
  logic [7:0] plain_reg [PLAIN_COUNT];
  logic [7:0] plain_next [PLAIN_COUNT];
  logic test_reg;
  logic test_next;
  logic [8*PROT_COUNT-1:0] prot_flat_next;

  // Access event to the guard
  logic ev_valid_c;
  srg_pkg::srg_kind_t ev_kind_c;
  logic ev_flag_c;

  // Working values of the write and read paths
  srg_pkg::srg_class_t wr_cls;
  srg_pkg::srg_class_t tgt_cls;
  logic [7:0] tgt_addr;
  logic [2:0] bit_num;
  logic [1:0] bit_op;
  logic [7:0] tgt_old;
  logic [7:0] tgt_new;
  int tgt_idx;
  srg_pkg::srg_class_t rd_cls;

  // Address class of a byte address
  function automatic srg_pkg::srg_class_t srg_decode(input logic [7:0] addr);
    logic [7:0] a;
    int ai;
    a = {addr[7:2], 2'b00};
    ai = int'(a);
    if (a == srg_pkg::CMD_OFFSET) begin
      return srg_pkg::CLS_CMD;
    end else if (a == srg_pkg::STATUS_OFFSET) begin
      return srg_pkg::CLS_STATUS;
    end else if (a == srg_pkg::BITOP_OFFSET) begin
      return srg_pkg::CLS_BITOP;
    end else if (ai >= int'(srg_pkg::PROT_BASE) &&
                 ai < int'(srg_pkg::PROT_BASE) + 4 * PROT_COUNT) begin
      return srg_pkg::CLS_PROT;
    end else if (ai >= int'(srg_pkg::PLAIN_BASE) &&
                 ai < int'(srg_pkg::PLAIN_BASE) + 4 * PLAIN_COUNT) begin
      return srg_pkg::CLS_PLAIN;
    end
    return srg_pkg::CLS_NONE;
  endfunction

  // Word index of an address within its bank
  function automatic int srg_index(input logic [7:0] addr, input logic [7:0] base);
    return (int'(addr) - int'(base)) >> 2;
  endfunction

  // Byte value of a data register
  function automatic logic [7:0] srg_peek(input srg_pkg::srg_class_t cls,
                                          input logic [7:0] addr);
    unique case (cls)
      srg_pkg::CLS_STATUS: return {7'h00, acc.perr};
      srg_pkg::CLS_PROT: return prot_reg[srg_index(addr, srg_pkg::PROT_BASE)];
      srg_pkg::CLS_PLAIN: return plain_reg[srg_index(addr, srg_pkg::PLAIN_BASE)];
      default: return 8'h00;
    endcase
  endfunction

  // Write path and access events
  always_comb begin
    aw_held_next = aw_held_reg;
    awaddr_next = awaddr_reg;
    w_held_next = w_held_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    prot_next = prot_reg;
    plain_next = plain_reg;
    test_next = test_reg;
    ev_valid_c = 1'b0;
    ev_kind_c = srg_pkg::KIND_OTHER;
    ev_flag_c = 1'b0;
    wr_cls = srg_decode(awaddr_reg);
    tgt_addr = wdata_reg[srg_pkg::BITOP_ADDR_LSB +: 8];
    tgt_cls = srg_decode(tgt_addr);
    bit_num = wdata_reg[srg_pkg::BITOP_NUM_LSB +: 3];
    bit_op = wdata_reg[srg_pkg::BITOP_OP_LSB +: 2];
    tgt_old = srg_peek(tgt_cls, tgt_addr);
    tgt_new = tgt_old;
    tgt_idx = 0;
    unique case (bit_op)
      srg_pkg::OP_SET: tgt_new[bit_num] = 1'b1;
      srg_pkg::OP_CLEAR: tgt_new[bit_num] = 1'b0;
      srg_pkg::OP_INVERT: tgt_new[bit_num] = ~tgt_old[bit_num];
      srg_pkg::OP_TEST: tgt_new = tgt_old;
    endcase
    if (s_axi_awvalid_i && awready_reg) begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && wready_reg) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata_i;
      wstrb_next = s_axi_wstrb_i;
    end
    if (bvalid_reg && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end
    if (aw_held_reg && w_held_reg && !bvalid_reg) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = srg_pkg::RESP_OKAY;
      unique case (wr_cls)
        srg_pkg::CLS_CMD: begin
          if (wstrb_reg == srg_pkg::STRB_BYTE0) begin
            ev_valid_c = 1'b1; // (R1)
            ev_kind_c = srg_pkg::KIND_CMD;
          end else begin
            bresp_next = srg_pkg::RESP_SLVERR; // (R1)
          end
        end
        srg_pkg::CLS_STATUS: begin
          if (wstrb_reg[0]) begin
            ev_valid_c = 1'b1; // (R10)
            ev_kind_c = srg_pkg::KIND_STATUS;
            ev_flag_c = wdata_reg[srg_pkg::PERR_BIT];
          end
        end
        srg_pkg::CLS_PROT: begin
          if (wstrb_reg[0]) begin
            ev_valid_c = 1'b1;
            ev_kind_c = srg_pkg::KIND_PROT;
            tgt_idx = srg_index(awaddr_reg, srg_pkg::PROT_BASE);
            if (acc.accept) begin
              prot_next[tgt_idx] = wdata_reg[7:0]; // (R12)
            end
          end
        end
        srg_pkg::CLS_PLAIN: begin
          if (wstrb_reg[0]) begin
            ev_valid_c = 1'b1; // (R4)
            ev_kind_c = srg_pkg::KIND_OTHER;
            tgt_idx = srg_index(awaddr_reg, srg_pkg::PLAIN_BASE);
            plain_next[tgt_idx] = wdata_reg[7:0];
          end
        end
        srg_pkg::CLS_BITOP: begin
          if (!wstrb_reg[0] || tgt_cls == srg_pkg::CLS_NONE ||
              tgt_cls == srg_pkg::CLS_CMD || tgt_cls == srg_pkg::CLS_BITOP) begin
            bresp_next = srg_pkg::RESP_SLVERR;
          end else if (bit_op == srg_pkg::OP_TEST) begin
            ev_valid_c = 1'b1; // (R5)
            ev_kind_c = srg_pkg::KIND_BITREAD;
            test_next = tgt_old[bit_num];
          end else begin
            ev_valid_c = 1'b1; // (R4)
            unique case (tgt_cls)
              srg_pkg::CLS_STATUS: begin
                ev_kind_c = srg_pkg::KIND_STATUS; // (R10)
                ev_flag_c = tgt_new[srg_pkg::PERR_BIT];
              end
              srg_pkg::CLS_PROT: begin
                ev_kind_c = srg_pkg::KIND_PROT;
                tgt_idx = srg_index(tgt_addr, srg_pkg::PROT_BASE);
                if (acc.accept) begin
                  prot_next[tgt_idx] = tgt_new; // (R12)
                end
              end
              default: begin
                ev_kind_c = srg_pkg::KIND_OTHER;
                tgt_idx = srg_index(tgt_addr, srg_pkg::PLAIN_BASE);
                plain_next[tgt_idx] = tgt_new;
              end
            endcase
          end
        end
        default: begin
          bresp_next = srg_pkg::RESP_SLVERR;
        end
      endcase
    end
    awready_next = !aw_held_next && !bvalid_next;
    wready_next = !w_held_next && !bvalid_next;
  end

  // Read path; plain reads never touch the guard
  always_comb begin
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    rd_cls = srg_decode(s_axi_araddr_i);
    if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
    if (s_axi_arvalid_i && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1; // (R5)
      rresp_next = srg_pkg::RESP_OKAY;
      rdata_next = 32'h00000000;
      unique case (rd_cls)
        srg_pkg::CLS_CMD: rdata_next[7:0] = srg_pkg::CMD_READ_VALUE; // (R1)
        srg_pkg::CLS_BITOP: rdata_next[srg_pkg::BITOP_TEST_BIT] = test_reg;
        srg_pkg::CLS_NONE: rresp_next = srg_pkg::RESP_SLVERR;
        default: rdata_next[7:0] = srg_peek(rd_cls, s_axi_araddr_i); // (R10)
      endcase
    end
  end

  always_comb begin
    prot_flat_next = '0;
    for (int i = 0; i < PROT_COUNT; i++) begin
      prot_flat_next[8*i +: 8] = prot_next[i];
    end
  end

  assign acc.ev_valid = ev_valid_c;
  assign acc.ev_kind = ev_kind_c;
  assign acc.ev_flag = ev_flag_c;

  srg_guard srg_guard_inst (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .acc(acc)
  );

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= srg_pkg::RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= srg_pkg::RESP_OKAY;
      test_reg <= 1'b0;
      for (int i = 0; i < PROT_COUNT; i++) begin
        prot_reg[i] <= srg_pkg::PROT_RESET;
      end
      for (int i = 0; i < PLAIN_COUNT; i++) begin
        plain_reg[i] <= srg_pkg::PLAIN_RESET;
      end
      protected_value_o <= '0;
    end else begin
      aw_held_reg <= aw_held_next;
      awaddr_reg <= awaddr_next;
      w_held_reg <= w_held_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      test_reg <= test_next;
      prot_reg <= prot_next;
      plain_reg <= plain_next;
      protected_value_o <= prot_flat_next;
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign irq_holdoff_o = acc.armed; // (R11)

endmodule

// File: srg_special_register_write_guard_bench.sv
// Self-checking bench for the special register write guard
`timescale 1ns/1ns
module srg_special_register_write_guard_bench;
  localparam logic [7:0] CMD = srg_pkg::CMD_OFFSET;
  localparam logic [7:0] STA = srg_pkg::STATUS_OFFSET;
  localparam logic [7:0] BOP = srg_pkg::BITOP_OFFSET;
  localparam logic [7:0] P0 = srg_pkg::PROT_BASE;
  localparam logic [7:0] P1 = srg_pkg::PROT_BASE + 8'h04;
  localparam logic [7:0] PLN = srg_pkg::PLAIN_BASE;
  localparam logic [1:0] OK = srg_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = srg_pkg::RESP_SLVERR;
  localparam logic [3:0] B0 = srg_pkg::STRB_BYTE0;
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, holdoff, hang;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [63:0] pv;
  int bad_count, cmp_count;
  srg_special_register_write_guard srg_special_register_write_guard_inst (
    .ref_clk_i(clk), .reset_i(rst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .protected_value_o(pv), .irq_holdoff_o(holdoff)
  );
  srg_cpu_model srg_cpu_model_inst (
    .ref_clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
    .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
    .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
    .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
    .rvalid_i(rvalid), .rready_o(rready), .hang_o(hang)
  );
  task automatic end_of_test();
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                   input logic [1:0] e);
    logic [1:0] r;
    srg_cpu_model_inst.wr(a, d, s, r);
    chk("bresp", 64'(r), 64'(e));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
    logic [31:0] d;
    logic [1:0] r;
    srg_cpu_model_inst.rd(a, d, r);
    chk("rdata", 64'(d), 64'(e));
    chk("rresp", 64'(r), 64'(re));
  endtask
  task automatic cmd();
    w(CMD, 32'hA5, B0, OK);
  endtask
  task automatic clr();
    w(STA, 32'h0, B0, OK);
  endtask
  function automatic logic [31:0] bop(input logic [1:0] op, input logic [7:0] t);
    return 32'(t) | (32'(op) << srg_pkg::BITOP_OP_LSB);
  endfunction
  task automatic t_reset();
    rd(STA, 32'h0, OK);
    rd(CMD, 32'(srg_pkg::CMD_READ_VALUE), OK);
    chk("hold", 64'(holdoff), 64'h0);
    chk("prot", pv, 64'h0);
  endtask
  task automatic t_unarmed();
    w(P0, 32'h5A, B0, OK);
    chk("prot0", 64'(pv[7:0]), 64'h0);
    rd(STA, 32'h1, OK);
    clr();
    rd(STA, 32'h0, OK);
  endtask
  task automatic t_armed();
    cmd();
    rd(PLN, 32'h0, OK);
    rd(STA, 32'h0, OK);
    chk("hold", 64'(holdoff), 64'h1);
    w(P1, 32'h3C, B0, OK);
    chk("prot1", 64'(pv[15:8]), 64'h3C);
    chk("hold", 64'(holdoff), 64'h0);
    rd(STA, 32'h0, OK);
    w(P1, 32'h77, B0, OK);
    chk("prot1", 64'(pv[15:8]), 64'h3C);
    rd(STA, 32'h1, OK);
    clr();
  endtask
  task automatic t_nonprot();
    for (int i = 0; i < 5; i++) begin
      cmd();
      if (i < 4) w(BOP, bop(2'(i), PLN), B0, OK);
      else w(PLN, 32'h11, B0, OK);
      chk("hold", 64'(holdoff), 64'h0);
      rd(STA, 32'h1, OK);
      clr();
    end
  endtask
  task automatic t_double();
    cmd();
    cmd();
    chk("hold", 64'(holdoff), 64'h0);
    rd(STA, 32'h1, OK);
    clr();
  endtask
  task automatic t_clear_wins();
    w(P0, 32'h1, B0, OK);
    cmd();
    clr();
    rd(STA, 32'h0, OK);
    w(P0, 32'h66, B0, OK);
    chk("prot0", 64'(pv[7:0]), 64'h0);
    rd(STA, 32'h1, OK);
    clr();
  endtask
  task automatic t_bitprot();
    cmd();
    w(BOP, bop(srg_pkg::OP_SET, P0) | 32'h200, B0, OK);
    chk("prot0", 64'(pv[7:0]), 64'h04);
    chk("hold", 64'(holdoff), 64'h0);
    rd(STA, 32'h0, OK);
    w(BOP, bop(srg_pkg::OP_INVERT, P0) | 32'h200, B0, OK);
    chk("prot0", 64'(pv[7:0]), 64'h04);
    rd(STA, 32'h1, OK);
    clr();
  endtask
  task automatic t_bits();
    w(BOP, bop(srg_pkg::OP_SET, STA), B0, OK);
    rd(STA, 32'h1, OK);
    w(BOP, bop(srg_pkg::OP_TEST, STA), B0, OK);
    rd(BOP, 32'h1, OK);
    w(BOP, bop(srg_pkg::OP_CLEAR, STA), B0, OK);
    rd(STA, 32'h0, OK);
    w(STA, 32'h1, B0, OK);
    rd(STA, 32'h1, OK);
    clr();
  endtask
  task automatic t_refused();
    w(CMD, 32'hA5, 4'h3, ERR);
    chk("hold", 64'(holdoff), 64'h0);
    w(8'hF0, 32'h1, B0, ERR);
    rd(8'hF0, 32'h0, ERR);
    w(STA, 32'h1, 4'h2, OK);
    rd(STA, 32'h0, OK);
  endtask
  task automatic t_midreset();
    w(P0, 32'h1, B0, OK);
    cmd();
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk("hold", 64'(holdoff), 64'h0);
    chk("prot", pv, 64'h0);
    rd(STA, 32'h0, OK);
  endtask
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (hang === 1'h1) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    rst = 1'h1;
    bad_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_unarmed();
    t_armed();
    t_nonprot();
    t_double();
    t_clear_wins();
    t_bitprot();
    t_bits();
    t_refused();
    t_midreset();
    end_of_test();
  end
endmodule
